// file: rfidh_host.sv
/*
 * rfidh_host: host master model on the serial link, select or delimiter mode.
 * Assumes the bench fills txb, calls xfer and reads back rxb.
 */
`timescale 1ns/10ps
`default_nettype none

module rfidh_host #(
    parameter int HALF = 250
) (
    // serial link pins
    output logic      sclk,
    output logic      mosi,
    output logic      ss_n,
    input  wire logic miso
);
    logic [7:0] txb [16];
    logic [7:0] rxb [16];
    logic       nss;

    initial begin
        sclk = 1'b0;
        mosi = 1'b0;
        ss_n = 1'b1;
        nss  = 1'b0;
    end

    // one frame of n words at 2 mhz; the clock stands low outside frames
    task automatic xfer(input int n);
        if (nss) begin
            // start delimiter: data rises while the clock is high
            mosi = 1'b0;
            #(HALF);
            sclk = 1'b1;
            #(HALF);
            mosi = 1'b1;
            #(HALF);
            sclk = 1'b0;
        end else begin
            ss_n = 1'b0;
        end
        #(HALF);
        for (int w = 0; w < n; w++) begin
            for (int b = 7; b >= 0; b--) begin
                mosi = txb[w][b];
                #(HALF);
                sclk = 1'b1;
                rxb[w][b] = miso;
                #(HALF);
                sclk = 1'b0;
            end
        end
        if (nss) begin
            // stop delimiter: data falls while the clock is high
            mosi = 1'b1;
            #(HALF);
            sclk = 1'b1;
            #(HALF);
            mosi = 1'b0;
            #(HALF);
            sclk = 1'b0;
        end else begin
            #(HALF);
            ss_n = 1'b1;
            mosi = ~mosi;
        end
        #(4 * HALF);
    endtask

endmodule // rfidh_host

`default_nettype wire

// file: rfidh_pkg.sv
/*
 * rfidh_pkg: constants shared by the reader host port.
 * Assumes nothing of its surroundings; compiled first.
 */
`default_nettype none

package rfidh_pkg;

    // register addresses (5-bit address field of the first word)
    localparam logic [4:0] REG_IRQ_STATUS  = 5'h0c;
    localparam logic [4:0] REG_COLL_MASK   = 5'h0d;
    localparam logic [4:0] REG_FIFO_STATUS = 5'h1c;
    localparam logic [4:0] REG_TX_LEN_UP   = 5'h1d;
    localparam logic [4:0] REG_TX_LEN_LO   = 5'h1e;
    localparam logic [4:0] REG_FIFO_DATA   = 5'h1f;

    // first word layout
    localparam int ADR_BIT_CMD  = 7;
    localparam int ADR_BIT_RD   = 6;
    localparam int ADR_BIT_CONT = 5;
    localparam logic [4:0] CMD_FIFO_RESET = 5'h0f;

    // interrupt status bits
    localparam int IRQ_B_TX    = 7;
    localparam int IRQ_B_SOF   = 6;
    localparam int IRQ_B_FIFO  = 5;
    localparam int IRQ_B_CRC   = 4;
    localparam int IRQ_B_FRAME = 2;

    // fifo status bits
    localparam int FS_B_OVF  = 4;
    localparam int FS_B_LOW  = 5;
    localparam int FS_B_HIGH = 6;

    // fifo levels and frame-size thresholds
    localparam logic [3:0] FIFO_DEPTH   = 4'hc;
    localparam logic [3:0] RX_SHORT_MAX = 4'h8;
    localparam logic [3:0] TX_LOW_LEVEL = 4'h3;
    localparam logic [11:0] TX_LONG_MIN = 12'h005;

    // strap codes for {io2, io1, io0} and the strap settle count
    localparam logic [2:0] STRAP_SPI_SS   = 3'h6;
    localparam logic [2:0] STRAP_SPI_NOSS = 3'h4;
    localparam logic [1:0] STRAP_SETTLE   = 2'h2;

    // reset values
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] MASK_RST   = 8'h00;
    localparam logic [7:0] LEN_RST    = 8'h00;

    typedef enum logic [1:0] {
        PR_IDLE,
        PR_WR,
        PR_RD,
        PR_CMD
    } rfidh_proto_type;

endpackage

`default_nettype wire

// file: rfidh_port.sv
/*
 * rfidh_port: serial host port, fifo and interrupt service of the reader.
 * Assumes the rf core drives rx/tx events on clk and a host master on sclk.
 */
`timescale 1ns/10ps
`default_nettype none

module rfidh_port
    import rfidh_pkg::*;
(
    // system clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // serial link pins
    input  wire logic        sclk,
    input  wire logic        mosi,
    input  wire logic        ss_n,
    input  wire logic [2:0]  strap,
    output logic             miso,
    // receive path from the rf core
    input  wire logic        rx_sof,
    input  wire logic        rx_push,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_done,
    input  wire logic        rx_crc_err,
    input  wire logic        rx_frame_err,
    // transmit path to the rf core
    input  wire logic        tx_pop,
    output logic [7:0]       tx_data,
    output logic             tx_start,
    output logic             tx_eof,
    output logic [3:0]       tx_partial_bits,
    // host attention
    output logic             irq
);
    // ---------------- link domain (sclk) ----------------
    logic       link_rst_n;
    logic [6:0] sh_q, sh_d;
    logic [2:0] bit_q, bit_d;
    logic [7:0] word_q, word_d;
    logic       tgl_q, tgl_d, got_q, got_d;
    logic [7:0] out_q, out_d;
    logic [7:0] rd_word_q, rd_word_d;
    logic       ss_mode_q, ss_mode_d, nss_mode_q, nss_mode_d;
    logic       frame_q, frame_d;

    assign link_rst_n = nrst & (ss_mode_q ? ~ss_n : (nss_mode_q & frame_q));

    always_comb begin
        sh_d   = {sh_q[5:0], mosi};
        bit_d  = bit_q + 3'h1;
        word_d = (bit_q == 3'h7) ? {sh_q, mosi} : word_q;
        tgl_d  = tgl_q ^ (bit_q == 3'h7);
        got_d  = got_q | (bit_q == 3'h7);
    end

    always_ff @(posedge sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            sh_q   <= 7'h00;
            bit_q  <= 3'h0;
            word_q <= 8'h00;
            tgl_q  <= 1'b0;
            got_q  <= 1'b0;
        end else begin
            sh_q   <= sh_d;
            bit_q  <= bit_d;
            word_q <= word_d;
            tgl_q  <= tgl_d;
            got_q  <= got_d;
        end
    end

    // load the prepared byte half a cycle after each eighth rising edge
    always_comb begin
        out_d = (bit_q == 3'h0 && got_q) ? rd_word_q : {out_q[6:0], 1'b0};
    end

    always_ff @(negedge sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            out_q <= 8'h00;
        end else begin
            out_q <= out_d;
        end
    end

    assign miso = out_q[7];

    // ---------------- pin synchronisation ----------------
    logic       sclk_s, mosi_s, ss_s, tgl_s;
    logic [2:0] strap_s;

    rfidh_sync #(.W(7)) u_sync (
        .clk  (clk),
        .nrst (nrst),
        .d    ({tgl_q, strap, ss_n, sclk, mosi}),
        .q    ({tgl_s, strap_s, ss_s, sclk_s, mosi_s})
    );

    // ---------------- mode and framing (clk) ----------------
    logic [1:0] settle_q, settle_d;
    logic       mosi_p_q, tgl_p_q;
    logic       link_live, byte_evt;

    always_comb begin
        settle_d   = settle_q;
        ss_mode_d  = ss_mode_q;
        nss_mode_d = nss_mode_q;
        frame_d    = frame_q;
        if (settle_q != STRAP_SETTLE + 2'h1) begin
            settle_d = settle_q + 2'h1;
        end
        if (settle_q == STRAP_SETTLE) begin
            ss_mode_d  = (strap_s == STRAP_SPI_SS);
            nss_mode_d = (strap_s == STRAP_SPI_NOSS);
        end
        if (!nss_mode_q) begin
            frame_d = 1'b0;
        end else if (sclk_s && mosi_s && !mosi_p_q) begin
            frame_d = 1'b1;
        end else if (sclk_s && !mosi_s && mosi_p_q) begin
            frame_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            settle_q   <= 2'h0;
            ss_mode_q  <= 1'b0;
            nss_mode_q <= 1'b0;
            frame_q    <= 1'b0;
            mosi_p_q   <= 1'b0;
            tgl_p_q    <= 1'b0;
        end else begin
            settle_q   <= settle_d;
            ss_mode_q  <= ss_mode_d;
            nss_mode_q <= nss_mode_d;
            frame_q    <= frame_d;
            mosi_p_q   <= mosi_s;
            tgl_p_q    <= tgl_s;
        end
    end

    assign link_live = ss_mode_q ? !ss_s : frame_q;
    assign byte_evt  = link_live && (tgl_s ^ tgl_p_q);

    // ---------------- registers, fifo, events (clk) ----------------
    logic [7:0]      mem [0:11];
    logic [3:0]      wp_q, wp_d, rp_q, rp_d, cnt_q, cnt_d;
    logic            ovf_q, ovf_d;
    rfidh_proto_type st_q, st_d;
    logic [4:0]      addr_q, addr_d;
    logic            cont_q, cont_d;
    logic [1:0]      clr_q, clr_d;
    logic [7:0]      status_q, status_d, mask_q, mask_d;
    logic [7:0]      len_hi_q, len_hi_d, len_lo_q, len_lo_d;
    logic            irq_q, irq_d, rx_act_q, rx_act_d, tx_act_q, tx_act_d;
    logic [11:0]     sent_q, sent_d, tx_len;
    logic            start_q, start_d, eof_q, eof_d;
    logic            h_push, h_pop, push_ok, pop_ok, fifo_clr, clr_all, irq_set;
    logic [7:0]      set_v, push_data;
    logic [4:0]      nxt_addr;

    function automatic logic [3:0] ptr_inc(input logic [3:0] p);
        return (p == FIFO_DEPTH - 4'h1) ? 4'h0 : p + 4'h1;
    endfunction

    function automatic logic [7:0] reg_rd(input logic [4:0] a);
        case (a)
            REG_IRQ_STATUS:  reg_rd = status_q;
            REG_COLL_MASK:   reg_rd = mask_q;
            REG_FIFO_STATUS: reg_rd = {1'b0, cnt_q >= RX_SHORT_MAX + 4'h1,
                                       cnt_q <= TX_LOW_LEVEL, ovf_q, cnt_q - 4'h1};
            REG_TX_LEN_UP:   reg_rd = len_hi_q;
            REG_TX_LEN_LO:   reg_rd = len_lo_q;
            REG_FIFO_DATA:   reg_rd = (cnt_q != 4'h0) ? mem[rp_q] : 8'h00;
            default:         reg_rd = 8'h00;
        endcase
    endfunction

    assign tx_len   = {len_hi_q, len_lo_q[7:4]};
    assign nxt_addr = addr_q + 5'h01;

    always_comb begin
        st_d = st_q;  addr_d = addr_q;  cont_d = cont_q;  clr_d = clr_q;
        rd_word_d = rd_word_q;  mask_d = mask_q;
        len_hi_d = len_hi_q;  len_lo_d = len_lo_q;
        h_push = 1'b0;  h_pop = 1'b0;  fifo_clr = 1'b0;  clr_all = 1'b0;
        if (byte_evt) begin
            if (clr_q == 2'h2) begin
                clr_all = 1'b1;
                clr_d   = 2'h0;
            end else if (clr_q == 2'h1) begin
                clr_d = 2'h2;
            end
            case (st_q)
                PR_IDLE: begin
                    if (word_q[ADR_BIT_CMD]) begin
                        fifo_clr = (word_q[4:0] == CMD_FIFO_RESET);
                        st_d     = PR_CMD;
                    end else begin
                        addr_d = word_q[4:0];
                        cont_d = word_q[ADR_BIT_CONT];
                        if (word_q[ADR_BIT_RD]) begin
                            st_d      = PR_RD;
                            rd_word_d = reg_rd(word_q[4:0]);
                            h_pop     = (word_q[4:0] == REG_FIFO_DATA);
                            if (word_q[4:0] == REG_IRQ_STATUS) begin
                                clr_d = 2'h1;
                            end
                        end else begin
                            st_d = PR_WR;
                        end
                    end
                end
                PR_WR: begin
                    case (addr_q)
                        REG_COLL_MASK: mask_d   = word_q;
                        REG_TX_LEN_UP: len_hi_d = word_q;
                        REG_TX_LEN_LO: len_lo_d = word_q;
                        REG_FIFO_DATA: h_push   = 1'b1;
                        default:       ;
                    endcase
                    if (cont_q) begin
                        addr_d = nxt_addr;
                    end else begin
                        st_d = PR_IDLE;
                    end
                end
                PR_RD: begin
                    if (cont_q) begin
                        addr_d    = nxt_addr;
                        rd_word_d = reg_rd(nxt_addr);
                        h_pop     = (nxt_addr == REG_FIFO_DATA);
                        if (nxt_addr == REG_IRQ_STATUS) begin
                            clr_d = 2'h1;
                        end
                    end else begin
                        st_d = PR_IDLE;
                    end
                end
                PR_CMD:  ;
                default: st_d = PR_IDLE;
            endcase
        end
        if (!link_live) begin
            st_d  = PR_IDLE;
            clr_d = 2'h0;
        end
    end

    always_comb begin
        pop_ok    = (h_pop || (tx_pop && tx_act_q)) && cnt_q != 4'h0;
        push_ok   = (h_push || rx_push) && (cnt_q != FIFO_DEPTH || pop_ok);
        push_data = h_push ? word_q : rx_data;
        wp_d = push_ok ? ptr_inc(wp_q) : wp_q;
        rp_d = pop_ok ? ptr_inc(rp_q) : rp_q;
        cnt_d = cnt_q + {3'h0, push_ok} - {3'h0, pop_ok};
        ovf_d = ovf_q | ((h_push || rx_push) && !push_ok);
        tx_act_d = tx_act_q;  sent_d = sent_q;  rx_act_d = rx_act_q;
        start_d = 1'b0;  eof_d = 1'b0;  set_v = 8'h00;  irq_set = 1'b0;
        if (h_push && push_ok && !tx_act_q) begin
            tx_act_d = 1'b1;
            sent_d   = 12'h000;
            start_d  = 1'b1;
            set_v[IRQ_B_TX] = 1'b1;
        end
        if (tx_pop && pop_ok) begin
            sent_d = sent_q + 12'h001;
            if (sent_q + 12'h001 >= tx_len) begin
                tx_act_d = 1'b0;
                eof_d    = 1'b1;
                set_v[IRQ_B_TX] = 1'b1;
                irq_set  = 1'b1;
            end else if (tx_len >= TX_LONG_MIN && cnt_d == TX_LOW_LEVEL) begin
                set_v[IRQ_B_FIFO] = 1'b1;
                irq_set = 1'b1;
            end
        end
        if (rx_sof) begin
            rx_act_d = 1'b1;
            set_v[IRQ_B_SOF] = 1'b1;
        end
        if (rx_push && push_ok && rx_act_q && cnt_q == RX_SHORT_MAX) begin
            set_v[IRQ_B_FIFO] = 1'b1;
            irq_set = 1'b1;
        end
        if (rx_act_q && rx_done) begin
            rx_act_d = 1'b0;
            set_v[IRQ_B_SOF] = 1'b1;
            irq_set  = 1'b1;
        end
        if (rx_act_q && (rx_crc_err || rx_frame_err)) begin
            rx_act_d = 1'b0;
            set_v[IRQ_B_CRC]   = rx_crc_err;
            set_v[IRQ_B_FRAME] = rx_frame_err;
            irq_set = 1'b1;
        end
        if (fifo_clr) begin
            wp_d = 4'h0;  rp_d = 4'h0;  cnt_d = 4'h0;  ovf_d = rx_push && !push_ok;
            tx_act_d = 1'b0;
        end
        status_d = (clr_all ? STATUS_RST : status_q) | set_v;
        irq_d    = (clr_all ? 1'b0 : irq_q) | irq_set;
    end

    always_ff @(posedge clk) begin
        if (push_ok) begin
            mem[wp_q] <= push_data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= PR_IDLE;  addr_q <= 5'h00;  cont_q <= 1'b0;  clr_q <= 2'h0;
            rd_word_q <= 8'h00;  status_q <= STATUS_RST;  mask_q <= MASK_RST;
            len_hi_q <= LEN_RST;  len_lo_q <= LEN_RST;  irq_q <= 1'b0;
            wp_q <= 4'h0;  rp_q <= 4'h0;  cnt_q <= 4'h0;  ovf_q <= 1'b0;
            tx_act_q <= 1'b0;  sent_q <= 12'h000;  rx_act_q <= 1'b0;
            start_q <= 1'b0;  eof_q <= 1'b0;
        end else begin
            st_q <= st_d;  addr_q <= addr_d;  cont_q <= cont_d;  clr_q <= clr_d;
            rd_word_q <= rd_word_d;  status_q <= status_d;  mask_q <= mask_d;
            len_hi_q <= len_hi_d;  len_lo_q <= len_lo_d;  irq_q <= irq_d;
            wp_q <= wp_d;  rp_q <= rp_d;  cnt_q <= cnt_d;  ovf_q <= ovf_d;
            tx_act_q <= tx_act_d;  sent_q <= sent_d;  rx_act_q <= rx_act_d;
            start_q <= start_d;  eof_q <= eof_d;
        end
    end

    assign tx_data         = mem[rp_q];
    assign tx_start        = start_q;
    assign tx_eof          = eof_q;
    assign tx_partial_bits = len_lo_q[3:0];
    assign irq             = irq_q;

    // ---------------- checks ----------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_sof;
        rx_sof |=> status_q[IRQ_B_SOF];
    endproperty
    a_sof: assert property (p_sof) else $error("sof flag not set");

    property p_rx_end;
        rx_act_q && rx_done |=> irq_q && !rx_act_q;
    endproperty
    a_rx_end: assert property (p_rx_end) else $error("no irq at rx end");

    property p_rx_high;
        rx_push && rx_act_q && cnt_q == 4'h8 && !fifo_clr |=> irq_q && status_q[IRQ_B_FIFO];
    endproperty
    a_rx_high: assert property (p_rx_high) else $error("no ninth-byte irq");

    property p_tx_go;
        h_push && push_ok && !tx_act_q && !fifo_clr
            |=> tx_start && status_q[IRQ_B_TX] ##1 !tx_start;
    endproperty
    a_tx_go: assert property (p_tx_go) else $error("tx start missing");

    property p_eof;
        tx_pop && tx_act_q && cnt_q != 4'h0 && sent_q + 12'h001 >= tx_len
            |=> tx_eof && irq_q && !tx_act_q;
    endproperty
    a_eof: assert property (p_eof) else $error("eof not at length");

    property p_tx_low;
        tx_act_q && tx_len < TX_LONG_MIN && !rx_act_q && !irq_q && !(tx_pop && cnt_q != 4'h0)
            |=> !irq_q;
    endproperty
    a_tx_low: assert property (p_tx_low) else $error("early irq short tx");

    property p_irq_clr;
        byte_evt && clr_q == 2'h2 && set_v == 8'h00 && !irq_set
            |=> status_q == STATUS_RST && !irq_q;
    endproperty
    a_irq_clr: assert property (p_irq_clr) else $error("status not cleared");

    property p_irq_flag;
        irq_q |-> status_q != STATUS_RST;
    endproperty
    a_irq_flag: assert property (p_irq_flag) else $error("irq without flag");

    property p_start;
        nss_mode_q && sclk_s && mosi_s && !mosi_p_q |=> frame_q;
    endproperty
    a_start: assert property (p_start) else $error("start missed");

    property p_cont;
        byte_evt && link_live && st_q == PR_WR && cont_q |=> addr_q == $past(addr_q) + 5'h01;
    endproperty
    a_cont: assert property (p_cont) else $error("address not stepped");

endmodule // rfidh_port

`default_nettype wire

// file: rfidh_port_tb.sv
/*
 * rfidh_port_tb: self-checking bench of the reader host port.
 * Assumes the host model drives the link and the bench plays the rf core.
 */
`timescale 1ns/10ps
`default_nettype none

module rfidh_port_tb;
    import rfidh_pkg::*;

    typedef struct packed {
        logic [4:0] adr;
        logic [7:0] wd;
        logic [7:0] rd;
    } rfidh_row_type;

    logic       clk, nrst, sclk, mosi, ss_n, miso, tx_start, tx_eof, irq;
    logic       rx_sof, rx_push, rx_done, rx_crc_err, rx_frame_err, tx_pop;
    logic [7:0] rx_data, tx_data;
    logic [3:0] tx_partial_bits;
    logic [2:0] strap;
    int         bad_count, comparisons, starts, eofs;
    rfidh_row_type rows [6] = '{{5'h0d, 8'ha5, 8'ha5}, {5'h1d, 8'h01, 8'h01},
        {5'h1e, 8'h2c, 8'h2c}, {5'h0c, 8'hff, 8'h00}, {5'h03, 8'h55, 8'h00},
        {5'h1c, 8'h11, 8'h2f}};

    rfidh_port u_rfidh_port (.clk(clk), .nrst(nrst), .sclk(sclk), .mosi(mosi),
        .ss_n(ss_n), .strap(strap), .miso(miso), .rx_sof(rx_sof),
        .rx_push(rx_push), .rx_data(rx_data), .rx_done(rx_done),
        .rx_crc_err(rx_crc_err), .rx_frame_err(rx_frame_err), .tx_pop(tx_pop),
        .tx_data(tx_data), .tx_start(tx_start), .tx_eof(tx_eof),
        .tx_partial_bits(tx_partial_bits), .irq(irq));
    rfidh_host u_rfidh_host (.sclk(sclk), .mosi(mosi), .ss_n(ss_n), .miso(miso));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        starts <= starts + int'(tx_start === 1'b1);
        eofs   <= eofs + int'(tx_eof === 1'b1);
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic conclude;
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // three-word frame, n of them sent
    task automatic frm(input int n, input logic [7:0] a, b, c);
        u_rfidh_host.txb[0] = a;
        u_rfidh_host.txb[1] = b;
        u_rfidh_host.txb[2] = c;
        u_rfidh_host.xfer(n);
    endtask

    // one-cycle rf core pulse {sof, push, done, crc, frame, pop}
    task automatic ev(input logic [5:0] e, input logic [7:0] d);
        @(negedge clk);
        {rx_sof, rx_push, rx_done, rx_crc_err, rx_frame_err, tx_pop} = e;
        rx_data = d;
        @(negedge clk);
        {rx_sof, rx_push, rx_done, rx_crc_err, rx_frame_err, tx_pop} = 6'h00;
        @(negedge clk);
    endtask

    // status read with the dummy word, then irq must be gone
    task automatic status(input logic [7:0] exp);
        frm(3, 8'h6c, 8'h00, 8'h00);
        chk(u_rfidh_host.rxb[1], exp);
        chk({7'h00, irq}, 8'h00);
    endtask

    task automatic tx_run(input int n);
        int s0;
        int e0;
        s0 = starts;
        e0 = eofs;
        frm(1, 8'h8f, 8'h00, 8'h00);
        frm(3, 8'h3d, 8'h00, 8'(n * 16));
        for (int i = 0; i < n; i++) begin
            u_rfidh_host.txb[2 * i] = 8'h1f;
            u_rfidh_host.txb[2 * i + 1] = 8'h30 + 8'(i);
        end
        u_rfidh_host.xfer(2 * n);
        chk(8'(starts - s0), 8'h01);
        chk({7'h00, irq}, 8'h00);
        for (int k = 1; k <= n; k++) begin
            chk(tx_data, 8'h30 + 8'(k - 1));
            ev(6'h01, 8'h00);
            chk({7'h00, irq}, 8'((n >= 5 && n - k <= 3) || k == n));
            chk(8'(eofs - e0), 8'(k == n));
        end
        status(n >= 5 ? 8'ha0 : 8'h80);
    endtask

    initial begin
        #1_500_000;
        bad_count++;
        conclude();
    end

    initial begin
        nrst = 1'b0;
        strap = STRAP_SPI_SS;
        {rx_sof, rx_push, rx_done, rx_crc_err, rx_frame_err, tx_pop} = 6'h00;
        rx_data = 8'h00;
        repeat (4) @(negedge clk);
        chk({irq, tx_start, tx_eof, miso, tx_partial_bits}, 8'h00);
        nrst = 1'b1;
        repeat (8) @(negedge clk);
        foreach (rows[i]) begin
            frm(2, {3'h0, rows[i].adr}, rows[i].wd, 8'h00);
            frm(2, {3'h2, rows[i].adr}, 8'h00, 8'h00);
            chk(u_rfidh_host.rxb[1], rows[i].rd);
        end
        chk({4'h0, tx_partial_bits}, 8'h0c);
        ev(6'h20, 8'h00);
        for (int k = 0; k < 3; k++) begin
            ev(6'h10, 8'h50 + 8'(k));
            chk({7'h00, irq}, 8'h00);
        end
        ev(6'h08, 8'h00);
        chk({7'h00, irq}, 8'h01);
        status(8'h40);
        for (int k = 0; k < 3; k++) begin
            u_rfidh_host.txb[2 * k] = 8'h5f;
            u_rfidh_host.txb[2 * k + 1] = 8'h00;
        end
        u_rfidh_host.xfer(6);
        for (int k = 0; k < 3; k++) begin
            chk(u_rfidh_host.rxb[2 * k + 1], 8'h50 + 8'(k));
        end
        ev(6'h20, 8'h00);
        for (int k = 0; k < 9; k++) begin
            ev(6'h10, 8'h60 + 8'(k));
            chk({7'h00, irq}, 8'(k == 8));
        end
        // both errors end the reception; later error and end pulses are ignored
        ev(6'h06, 8'h00);
        ev(6'h02, 8'h00);
        ev(6'h08, 8'h00);
        status(8'h74);
        tx_run(4);
        tx_run(5);
        // second reset: straps now pick the link without select
        @(negedge clk);
        nrst = 1'b0;
        strap = STRAP_SPI_NOSS;
        u_rfidh_host.nss = 1'b1;
        repeat (4) @(negedge clk);
        chk({irq, tx_start, tx_eof, miso, tx_partial_bits}, 8'h00);
        nrst = 1'b1;
        repeat (8) @(negedge clk);
        frm(2, 8'h0d, 8'h3c, 8'h00);
        frm(2, 8'h4d, 8'h00, 8'h00);
        chk(u_rfidh_host.rxb[1], 8'h3c);
        ev(6'h20, 8'h00);
        ev(6'h08, 8'h00);
        chk({7'h00, irq}, 8'h01);
        status(8'h40);
        conclude();
    end

endmodule // rfidh_port_tb

`default_nettype wire

// file: rfidh_sync.sv
/*
 * rfidh_sync: two-stage synchroniser for a bundle of level inputs.
 * Assumes each bit is a slow level or a toggle from another domain.
 */
`timescale 1ns/10ps
`default_nettype none

module rfidh_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         nrst,
    // levels in and out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;

endmodule // rfidh_sync

`default_nettype wire
